// file: bus_common_pkg.sv
// package for the common bus control block: offsets, field positions, reset values, types
// assumes a single 250 MHz clock and a 32-bit AHB-Lite register bus
package bus_common_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] COMMON_BUS_CONTROL_OFS = 12'h000;
    localparam int          ADDR_LSB               = 2;

    // ------------------------------------------------------------
    // field positions of the common control word
    // ------------------------------------------------------------
    localparam int MAP_POS          = 12;
    localparam int RSVD_HI_ONE_POS  = 4;
    localparam int ENDIAN_POS       = 3;
    localparam int RSVD_LO_ONE_POS  = 2;
    localparam int MEM_DRIVE_POS    = 1;
    localparam int CLK_DRIVE_POS    = 0;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic MAP_RST        = 1'b0;
    localparam logic MEM_DRIVE_RST  = 1'b0;
    localparam logic CLK_DRIVE_RST  = 1'b0;
    localparam logic ENDIAN_RST     = 1'b0;

    // ------------------------------------------------------------
    // cycle counts
    // ------------------------------------------------------------
    localparam int STRAP_SETTLE_CYCLES = 3;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic map_two;
        logic little_endian;
        logic mem_pin_drive;
        logic clk_pin_drive;
    } bus_cfg_type;

    typedef struct packed {
        logic mem_pins_oe;
        logic clk_pins_oe;
        logic area5_use_b;
        logic area6_use_b;
    } pin_ctrl_type;

endpackage

// file: strap_sync.sv
// three-stage synchroniser for a strap pin with agreement filter
// assumes the pin is quasi-static around reset release
`timescale 1ns/1ps
`default_nettype none
module strap_sync
    import bus_common_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    input  wire logic pin_in,
    output var  logic level_out,
    output var  logic stable_out
);
    logic [2:0] sync_ff;
    logic       level_ff;
    logic       stable_ff;

    // ------------------------------------------------------------
    // capture chain
    // ------------------------------------------------------------
    // first stage is read only by the second stage
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sync_ff <= 3'h0;
        end else begin
            sync_ff <= {sync_ff[1:0], pin_in};
        end
    end

    // level follows only when stages two and three agree; the agreement is
    // registered beside it so stable_out never runs ahead of level_out
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            level_ff  <= 1'b0;
            stable_ff <= 1'b0;
        end else begin
            stable_ff <= (sync_ff[1] == sync_ff[2]);
            if (sync_ff[1] == sync_ff[2]) begin
                level_ff <= sync_ff[2];
            end
        end
    end

    assign level_out  = level_ff;
    assign stable_out = stable_ff;
endmodule
`default_nettype wire

// file: bus_common_control.sv
// common control register of the external bus unit, AHB-Lite slave
// assumes power-on reset drives rst_b_in and the strap pin is steady around its release
//
// Design decisions made here: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module bus_common_control
    import bus_common_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output var  logic [31:0] hrdata_out,
    output var  logic        hreadyout_out,
    output var  logic        hresp_out,
    input  wire logic        byte_order_pin_in,
    input  wire logic        standby_in,
    output var  logic        little_endian_out,
    output var  logic        map_two_out,
    output var  logic        mem_pins_oe_out,
    output var  logic        clk_pins_oe_out,
    output var  logic        area5_use_b_out,
    output var  logic        area6_use_b_out,
    output var  logic        strap_done_out
);
    bus_cfg_type  cfg_ff;
    pin_ctrl_type pins_ff;
    pin_ctrl_type nxt_pins;
    logic         wr_pend_ff;
    logic         rd_pend_ff;
    logic [31:0]  hrdata_ff;
    logic [31:0]  reg_word;
    logic         strap_level;
    logic         strap_stable;
    logic [1:0]   settle_ff;
    logic         strap_done_ff;
    logic         addr_hit;
    logic         take;
    logic         strap_latch;
    bus_cfg_type  live_cfg;

    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    strap_sync u_strap (
        .clk_in     (clk_in),
        .rst_b_in   (rst_b_in),
        .pin_in     (byte_order_pin_in),
        .level_out  (strap_level),
        .stable_out (strap_stable)
    );

    // wait for the chain to fill, then latch once; no later pin change is seen
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            settle_ff     <= 2'h0;
            strap_done_ff <= 1'b0;
        end else if (!strap_done_ff) begin
            if (settle_ff != 2'(STRAP_SETTLE_CYCLES)) begin
                settle_ff <= settle_ff + 2'h1;
            end else if (strap_stable) begin
                strap_done_ff <= 1'b1;
            end
        end
    end

    // the latch fires once: chain full, the two late stages agreed one edge ago
    assign strap_latch = !strap_done_ff && settle_ff == 2'(STRAP_SETTLE_CYCLES) && strap_stable;

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    assign addr_hit = (haddr_in[11:ADDR_LSB] == COMMON_BUS_CONTROL_OFS[11:ADDR_LSB]);
    assign take     = hsel_in && htrans_in[1] && hready_in;

    // zero-wait slave: address phase recorded, data phase completes next cycle
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
        end else if (hready_in) begin
            wr_pend_ff <= take && hwrite_in && addr_hit;
            rd_pend_ff <= take && !hwrite_in && addr_hit;
        end
    end

    // the word as it stands after this edge: a write in its data phase and the
    // strap latch are folded in, so a read right behind a write sees the new word
    always_comb begin
        live_cfg = cfg_ff;
        if (strap_latch) begin
            live_cfg.little_endian = strap_level;
        end
        if (wr_pend_ff) begin
            // only writable fields load; read-only and reserved bits are dropped
            live_cfg.map_two       = hwdata_in[MAP_POS];
            live_cfg.mem_pin_drive = hwdata_in[MEM_DRIVE_POS];
            live_cfg.clk_pin_drive = hwdata_in[CLK_DRIVE_POS];
        end
    end

    // one process owns the whole settings word, so no field has two drivers
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cfg_ff.map_two       <= MAP_RST;
            cfg_ff.little_endian <= ENDIAN_RST;
            cfg_ff.mem_pin_drive <= MEM_DRIVE_RST;
            cfg_ff.clk_pin_drive <= CLK_DRIVE_RST;
        end else begin
            cfg_ff <= live_cfg;
        end
    end

    // read word: reserved zero, fixed ones, fields as they stand after this edge
    always_comb begin
        reg_word                  = 32'h0000_0000;
        reg_word[MAP_POS]         = live_cfg.map_two;
        reg_word[RSVD_HI_ONE_POS] = 1'b1;
        reg_word[ENDIAN_POS]      = live_cfg.little_endian;
        reg_word[RSVD_LO_ONE_POS] = 1'b1;
        reg_word[MEM_DRIVE_POS]   = live_cfg.mem_pin_drive;
        reg_word[CLK_DRIVE_POS]   = live_cfg.clk_pin_drive;
    end

    // read data registered at the address phase so it stands through the data phase
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (hready_in) begin
            hrdata_ff <= (take && !hwrite_in && addr_hit) ? reg_word : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // pin drive and area routing
    // ------------------------------------------------------------
    // outside standby the pins are driven from the first edge after reset; in standby the drive bits decide
    always_comb begin
        nxt_pins.mem_pins_oe = !standby_in || cfg_ff.mem_pin_drive;
        nxt_pins.clk_pins_oe = !standby_in || cfg_ff.clk_pin_drive;
        nxt_pins.area5_use_b = cfg_ff.map_two;
        nxt_pins.area6_use_b = cfg_ff.map_two;
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pins_ff <= '0;
        end else begin
            pins_ff <= nxt_pins;
        end
    end

    assign hrdata_out        = hrdata_ff;
    assign hreadyout_out     = 1'b1;
    assign hresp_out         = 1'b0;
    assign little_endian_out = cfg_ff.little_endian;
    assign map_two_out       = cfg_ff.map_two;
    assign mem_pins_oe_out   = pins_ff.mem_pins_oe;
    assign clk_pins_oe_out   = pins_ff.clk_pins_oe;
    assign area5_use_b_out   = pins_ff.area5_use_b;
    assign area6_use_b_out   = pins_ff.area6_use_b;
    assign strap_done_out    = strap_done_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    chk_fixed_ones: assert property (
        rd_pend_ff |-> hrdata_out[RSVD_HI_ONE_POS] && hrdata_out[RSVD_LO_ONE_POS])
        else $error("fixed one bits not read as one");
    chk_reserved_zero: assert property (
        rd_pend_ff |-> hrdata_out[31:13] == 19'h0 && hrdata_out[11:5] == 7'h0)
        else $error("reserved bits not zero");
    chk_map_write: assert property (
        wr_pend_ff |=> map_two_out == $past(hwdata_in[MAP_POS]))
        else $error("map bit did not follow write");
    chk_endian_locked: assert property (strap_done_ff |=> $stable(little_endian_out))
        else $error("byte order changed after latch");
    chk_endian_read: assert property (
        rd_pend_ff |-> hrdata_out[ENDIAN_POS] == little_endian_out)
        else $error("endian flag read mismatch");
    chk_mem_drive: assert property (
        standby_in && !cfg_ff.mem_pin_drive |=> !mem_pins_oe_out)
        else $error("memory pins driven in standby");
    chk_clk_standby: assert property (
        standby_in && !cfg_ff.clk_pin_drive |=> !clk_pins_oe_out)
        else $error("clock pins driven in standby");
    // the release edge itself still loads reset values, so it is left out
    chk_clk_drive: assert property (
        !standby_in && rst_b_in |=> clk_pins_oe_out)
        else $error("clock pins released outside standby");
    chk_mem_awake: assert property (
        !standby_in && rst_b_in |=> mem_pins_oe_out)
        else $error("memory pins released outside standby");
    chk_area_route: assert property (
        ##1 area5_use_b_out == $past(map_two_out) && area6_use_b_out == area5_use_b_out)
        else $error("area b routing does not follow map");
    chk_strap_time: assert property (
        $rose(strap_done_ff) |-> $past(settle_ff) == 2'(STRAP_SETTLE_CYCLES))
        else $error("strap latched too early");

    cov_write: cover property (wr_pend_ff ##1 map_two_out);
    cov_read: cover property (rd_pend_ff);
    cov_standby_hiz: cover property (standby_in ##1 !mem_pins_oe_out);
    cov_little: cover property ($rose(strap_done_ff) && little_endian_out);
    cov_area_b: cover property (map_two_out ##1 area6_use_b_out);
endmodule
`default_nettype wire

// file: ext_mem_side.sv
// behavioural stand-in for the memories on the chip-select areas
// assumes the pin enables come from the design's registered outputs
`timescale 1ns/1ps
`default_nettype none
module ext_mem_side (
    input  wire logic clk_in,
    input  wire logic mem_pins_oe_in,
    input  wire logic clk_pins_oe_in,
    output var  logic mem_float_out,
    output var  logic clk_float_out
);
    // ------------------------------------------------------------
    // pin state as the memories see it
    // ------------------------------------------------------------
    // sampled on the clock, the memories never look between edges
    always_ff @(posedge clk_in) begin
        mem_float_out <= !mem_pins_oe_in;
        clk_float_out <= !clk_pins_oe_in;
    end
endmodule
`default_nettype wire

// file: testbench.sv
// self-checking bench for the common bus control register
// assumes the design files and ext_mem_side are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench
    import bus_common_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        clk, rst_b, hsel, hwrite, pin, standby;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic        hready, hresp, le, map2, mem_oe, clk_oe, a5b, a6b, done;
    logic        mem_float, clk_float;
    int          n_fail, checks_done;

    bus_common_control dut (.clk_in(clk), .rst_b_in(rst_b), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
        .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp), .byte_order_pin_in(pin),
        .standby_in(standby), .little_endian_out(le), .map_two_out(map2),
        .mem_pins_oe_out(mem_oe), .clk_pins_oe_out(clk_oe), .area5_use_b_out(a5b),
        .area6_use_b_out(a6b), .strap_done_out(done));
    ext_mem_side mem (.clk_in(clk), .mem_pins_oe_in(mem_oe), .clk_pins_oe_in(clk_oe),
        .mem_float_out(mem_float), .clk_float_out(clk_float));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] word(logic mp, logic e, logic m, logic c);
        return {19'h0, mp, 7'h0, 1'b1, e, 1'b1, m, c};
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one single transfer; waits on hready, only the watchdog ends a hang
    task automatic bus(input logic wr, input logic [31:0] adr, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= adr;
        hwrite <= wr;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    // reads the given address, the control word or an unmapped one, and checks the word
    task automatic rd_chk(input string what, input logic [31:0] adr, input logic [31:0] exp);
        bus(1'b0, adr, 32'h0);
        chk(what, exp, rd);
    endtask
    task automatic do_reset(input logic p);
        pin <= p;
        rst_b <= 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 20 && done !== 1'b1; i++) @(posedge clk);
        chk("strap done", 32'h1, 32'(done));
    endtask
    task automatic settle();
        // ends on an edge, so the next stimulus change still lands on a rising edge
        repeat (4) @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_word();
        rd_chk("reset word", 32'h0, word(1'b0, 1'b0, 1'b0, 1'b0));
        chk("endian out", 32'h0, 32'(le));
        $display("reset word test done");
    endtask
    task automatic t_fields();
        bus(1'b1, 32'h0, 32'h0000101F);
        settle();
        chk("map out", 32'h1, 32'(map2));
        chk("area b", 32'h3, {30'h0, a5b, a6b});
        rd_chk("all ones", 32'h0, word(1'b1, 1'b0, 1'b1, 1'b1));
        bus(1'b1, 32'h0, 32'h00000014);
        settle();
        chk("area b off", 32'h0, {30'h0, a5b, a6b});
        rd_chk("all zeros", 32'h0, word(1'b0, 1'b0, 1'b0, 1'b0));
        $display("field test done");
    endtask
    task automatic t_standby();
        standby <= 1'b1;
        for (int v = 0; v < 4; v++) begin
            bus(1'b1, 32'h0, 32'h00000014 | 32'(v));
            settle();
            chk("mem float", 32'(v < 2), 32'(mem_float));
            chk("clk float", 32'(v % 2 == 0), 32'(clk_float));
        end
        standby <= 1'b0;
        bus(1'b1, 32'h0, 32'h00000014);
        settle();
        chk("awake drive", 32'h0, {30'h0, mem_float, clk_float});
        $display("standby test done");
    endtask
    task automatic t_unmapped();
        bus(1'b1, 32'h4, 32'hFFFFFFFF);
        rd_chk("unmapped", 32'h4, 32'h0);
        chk("okay resp", 32'h0, 32'(hresp));
        rd_chk("after unmapped", 32'h0, word(1'b0, 1'b0, 1'b0, 1'b0));
        $display("unmapped test done");
    endtask
    task automatic t_endian();
        do_reset(1'b1);
        chk("little out", 32'h1, 32'(le));
        rd_chk("little word", 32'h0, word(1'b0, 1'b1, 1'b0, 1'b0));
        bus(1'b1, 32'h0, 32'h00000014);
        rd_chk("flag kept", 32'h0, word(1'b0, 1'b1, 1'b0, 1'b0));
        $display("endian test done");
    endtask

    // ------------------------------------------------------------
    // run and verdict
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // roughly 130 cycles of work; about thirty times that means a hang
    initial begin
        #16000;
        n_fail++;
        end_of_test();
    end
    initial begin
        {hsel, hwrite, standby, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        n_fail = 0;
        checks_done = 0;
        do_reset(1'b0);
        t_reset_word();
        t_fields();
        t_standby();
        t_unmapped();
        t_endian();
        end_of_test();
    end
endmodule
`default_nettype wire
